// ==== crt_timing_pkg.sv ====
// Constants shared by the character raster timing generator
package crt_timing_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [4:0] IDX_HORIZONTAL_TOTAL  = 5'h00;
    localparam logic [4:0] IDX_HORIZONTAL_DISP   = 5'h01;
    localparam logic [4:0] IDX_HSYNC_POSITION    = 5'h02;
    localparam logic [4:0] IDX_HSYNC_WIDTH       = 5'h03;
    localparam logic [4:0] IDX_VERTICAL_TOTAL    = 5'h04;
    localparam logic [4:0] IDX_VERTICAL_ADJUST   = 5'h05;
    localparam logic [4:0] IDX_VERTICAL_DISP     = 5'h06;
    localparam logic [4:0] IDX_VSYNC_POSITION    = 5'h07;
    localparam logic [4:0] IDX_INTERLACE_MODE    = 5'h08;
    localparam logic [4:0] IDX_MAX_SCAN_LINE     = 5'h09;
    localparam logic [4:0] IDX_CURSOR_START      = 5'h0a;
    localparam logic [4:0] IDX_CURSOR_END        = 5'h0b;
    localparam logic [4:0] IDX_START_HIGH        = 5'h0c;
    localparam logic [4:0] IDX_START_LOW         = 5'h0d;
    localparam logic [4:0] IDX_CURSOR_HIGH       = 5'h0e;
    localparam logic [4:0] IDX_CURSOR_LOW        = 5'h0f;
    localparam logic [4:0] IDX_PEN_HIGH          = 5'h10;
    localparam logic [4:0] IDX_PEN_LOW           = 5'h11;
    localparam logic [4:0] IDX_STATUS            = 5'h12;

    // ==========================================================
    // Reset values of the timing registers
    localparam logic [7:0] RST_HORIZONTAL_TOTAL  = 8'h3f;
    localparam logic [7:0] RST_HORIZONTAL_DISP   = 8'h28;
    localparam logic [7:0] RST_HSYNC_POSITION    = 8'h2d;
    localparam logic [3:0] RST_HSYNC_WIDTH       = 4'h4;
    localparam logic [6:0] RST_VERTICAL_TOTAL    = 7'h1f;
    localparam logic [4:0] RST_VERTICAL_ADJUST   = 5'h00;
    localparam logic [6:0] RST_VERTICAL_DISP     = 7'h19;
    localparam logic [6:0] RST_VSYNC_POSITION    = 7'h1c;
    localparam logic [4:0] RST_MAX_SCAN_LINE     = 5'h07;

    // ==========================================================
    // Field positions and fixed timing
    localparam int         CURSOR_MODE_LSB       = 5;
    localparam logic [1:0] CURSOR_MODE_OFF       = 2'h1;
    localparam logic [1:0] CURSOR_MODE_FAST      = 2'h2;
    localparam int         BLINK_FAST_BIT        = 3;
    localparam int         BLINK_SLOW_BIT        = 4;
    localparam logic [4:0] VSYNC_LINES           = 5'h10;
    localparam int         ADDR_WIDTH            = 14;

    // ==========================================================
    // Vertical sequencer states
    typedef enum logic [0:0] {
        V_ROWS   = 1'b0,
        V_ADJUST = 1'b1
    } vstate_type;

endpackage

// ==== pin_synchronizer.sv ====
// Two-flop synchroniser for an asynchronous input pin
`timescale 1ns/1ns
module pin_synchronizer
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_reg;

    // ==========================================================
    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ==== crt_raster_timing_generator.sv ====
// Character raster timing generator with APB register file
// ==========================================================
// Overview of operation
// - Output 14-bit refresh address and 5-bit raster row address per position.
// - Each frame starts refresh address at the programmed start address.
// - Pen address registers change only on pen strobe, never by host write.
// - Scan line lasts horizontal total plus one character clocks.
// - Character row lasts max scan line plus one scan lines.
// - Frame is (vertical total plus one) rows plus adjust scan lines.
// - Horizontal sync lasts the programmed width in character clocks.
// - Vertical total holds rows minus one; adjust holds extra scan lines.
// - Synchronised pen strobe rising edge captures current refresh address.
// - Interlace bits: x0 normal, 01 interlace sync, 11 sync and video; here 01 and 11 alike only toggle the field flag.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
module crt_raster_timing_generator
    import crt_timing_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [6:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pen_strobe_input,
    output logic [13:0]      refresh_memory_address,
    output logic [4:0]       raster_row_address,
    output logic             horizontal_sync,
    output logic             vertical_sync,
    output logic             display_enable,
    output logic             cursor_active,
    output logic             interlace_field
);

    // ==========================================================
    // Register file
    logic [7:0]  horizontal_total_reg;
    logic [7:0]  horizontal_disp_reg;
    logic [7:0]  hsync_position_reg;
    logic [3:0]  hsync_width_reg;
    logic [6:0]  vertical_total_reg;
    logic [4:0]  vertical_adjust_reg;
    logic [6:0]  vertical_disp_reg;
    logic [6:0]  vsync_position_reg;
    logic [1:0]  interlace_mode_reg;
    logic [4:0]  max_scan_line_reg;
    logic [6:0]  cursor_start_reg;
    logic [4:0]  cursor_end_reg;
    logic [13:0] start_address_reg;
    logic [13:0] cursor_location_reg;
    logic [13:0] pen_address_reg;
    logic [31:0] prdata_reg;

    // Raster state
    logic [7:0]  h_count_reg;
    logic [3:0]  hsync_left_reg;
    logic [4:0]  row_line_reg;
    logic [6:0]  row_count_reg;
    logic [4:0]  adjust_count_reg;
    logic [4:0]  vsync_left_reg;
    vstate_type  vstate_reg;
    logic [13:0] ma_reg;
    logic [13:0] row_start_reg;
    logic        field_reg;
    logic [4:0]  blink_count_reg;
    logic        pen_sync;
    logic        pen_prev_reg;

    // ==========================================================
    // Bus decode
    wire  [4:0]  reg_index  = paddr[6:2];
    wire         bus_setup  = psel && !penable;
    wire         bus_write  = psel && penable && pwrite;
    wire         mapped     = (reg_index <= IDX_STATUS);
    wire  [7:0]  wbyte      = pwdata[7:0];
    wire         wr_en      = bus_write && mapped;

    // Zero-wait slave; unmapped indices flag an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_reg;

    // Read mux; write-only timing registers read as zero
    logic [31:0] read_value;
    always_comb
    begin
        read_value = 32'h0000_0000;
        case (reg_index)
            IDX_CURSOR_HIGH: read_value = {26'h0, cursor_location_reg[13:8]};
            IDX_CURSOR_LOW:  read_value = {24'h0, cursor_location_reg[7:0]};
            IDX_PEN_HIGH:    read_value = {26'h0, pen_address_reg[13:8]};
            IDX_PEN_LOW:     read_value = {24'h0, pen_address_reg[7:0]};
            IDX_STATUS:      read_value = {22'h0, field_reg, vertical_sync, horizontal_sync,
                                           display_enable, vstate_reg, raster_row_address};
            default:         read_value = 32'h0000_0000;
        endcase
    end

    // Read data latched in the setup phase, stable through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (bus_setup)
            prdata_reg <= read_value;
    end

    // ==========================================================
    // Host-written registers; pen pair is absent here on purpose
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            horizontal_total_reg <= RST_HORIZONTAL_TOTAL;
            horizontal_disp_reg  <= RST_HORIZONTAL_DISP;
            hsync_position_reg   <= RST_HSYNC_POSITION;
            hsync_width_reg      <= RST_HSYNC_WIDTH;
            vertical_total_reg   <= RST_VERTICAL_TOTAL;
            vertical_adjust_reg  <= RST_VERTICAL_ADJUST;
            vertical_disp_reg    <= RST_VERTICAL_DISP;
            vsync_position_reg   <= RST_VSYNC_POSITION;
            interlace_mode_reg   <= 2'h0;
            max_scan_line_reg    <= RST_MAX_SCAN_LINE;
            cursor_start_reg     <= 7'h00;
            cursor_end_reg       <= 5'h00;
            start_address_reg    <= 14'h0000;
            cursor_location_reg  <= 14'h0000;
        end
        else if (wr_en)
        begin
            case (reg_index)
                IDX_HORIZONTAL_TOTAL: horizontal_total_reg <= wbyte;
                IDX_HORIZONTAL_DISP:  horizontal_disp_reg  <= wbyte;
                IDX_HSYNC_POSITION:   hsync_position_reg   <= wbyte;
                IDX_HSYNC_WIDTH:      hsync_width_reg      <= wbyte[3:0];
                IDX_VERTICAL_TOTAL:   vertical_total_reg   <= wbyte[6:0];
                IDX_VERTICAL_ADJUST:  vertical_adjust_reg  <= wbyte[4:0];
                IDX_VERTICAL_DISP:    vertical_disp_reg    <= wbyte[6:0];
                IDX_VSYNC_POSITION:   vsync_position_reg   <= wbyte[6:0];
                IDX_INTERLACE_MODE:   interlace_mode_reg   <= wbyte[1:0];
                IDX_MAX_SCAN_LINE:    max_scan_line_reg    <= wbyte[4:0];
                IDX_CURSOR_START:     cursor_start_reg     <= wbyte[6:0];
                IDX_CURSOR_END:       cursor_end_reg       <= wbyte[4:0];
                IDX_START_HIGH:       start_address_reg[13:8] <= wbyte[5:0];
                IDX_START_LOW:        start_address_reg[7:0]  <= wbyte;
                IDX_CURSOR_HIGH:      cursor_location_reg[13:8] <= wbyte[5:0];
                IDX_CURSOR_LOW:       cursor_location_reg[7:0]  <= wbyte;
                default:              ;
            endcase
        end
    end

    // ==========================================================
    // Light pen capture; strobe is asynchronous to the raster
    pin_synchronizer pen_sync_inst
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pen_strobe_input),
        .sync_out (pen_sync)
    );

    wire pen_rise = pen_sync && !pen_prev_reg;

    // Only the strobe loads the pair; host writes never reach it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pen_prev_reg    <= 1'b0;
            pen_address_reg <= 14'h0000;
        end
        else
        begin
            pen_prev_reg <= pen_sync;
            if (pen_rise)
                pen_address_reg <= ma_reg;
        end
    end

    // ==========================================================
    // Horizontal and vertical event decode
    wire line_end     = (h_count_reg == horizontal_total_reg);
    wire row_end      = (vstate_reg == V_ROWS) && (row_line_reg == max_scan_line_reg);
    wire last_row     = (row_count_reg == vertical_total_reg);
    wire adjust_done  = (vstate_reg == V_ADJUST) && (adjust_count_reg == vertical_adjust_reg - 5'h01);
    // Frame ends after the last row, or after the adjust lines if any
    wire frame_end    = line_end && (adjust_done ||
                        (row_end && last_row && vertical_adjust_reg == 5'h00));
    wire h_active     = (h_count_reg < horizontal_disp_reg);
    wire v_active     = (vstate_reg == V_ROWS) && (row_count_reg < vertical_disp_reg);
    wire hsync_start  = (h_count_reg == hsync_position_reg);
    wire vsync_start  = (h_count_reg == 8'h00) && (vstate_reg == V_ROWS) &&
                        (row_line_reg == 5'h00) && (row_count_reg == vsync_position_reg);
    wire interlaced   = (interlace_mode_reg == 2'h1) || (interlace_mode_reg == 2'h3);
    wire [13:0] next_row_start = row_start_reg + {6'h00, horizontal_disp_reg};

    // Character counter and horizontal sync width counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            h_count_reg    <= 8'h00;
            hsync_left_reg <= 4'h0;
        end
        else
        begin
            h_count_reg <= line_end ? 8'h00 : h_count_reg + 8'h01;
            if (hsync_start)
                hsync_left_reg <= hsync_width_reg;
            else if (hsync_left_reg != 4'h0)
                hsync_left_reg <= hsync_left_reg - 4'h1;
        end
    end

    // ==========================================================
    // Vertical sequencer: rows, then adjust scan lines
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vstate_reg       <= V_ROWS;
            row_line_reg     <= 5'h00;
            row_count_reg    <= 7'h00;
            adjust_count_reg <= 5'h00;
        end
        else if (frame_end)
        begin
            vstate_reg       <= V_ROWS;
            row_line_reg     <= 5'h00;
            row_count_reg    <= 7'h00;
            adjust_count_reg <= 5'h00;
        end
        else if (line_end)
        begin
            case (vstate_reg)
                V_ROWS:
                begin
                    row_line_reg <= row_end ? 5'h00 : row_line_reg + 5'h01;
                    if (row_end && last_row)
                        vstate_reg <= V_ADJUST;
                    else if (row_end)
                        row_count_reg <= row_count_reg + 7'h01;
                end
                V_ADJUST:
                    adjust_count_reg <= adjust_count_reg + 5'h01;
                default:
                    vstate_reg <= V_ROWS;
            endcase
        end
    end

    // Vertical sync spans a fixed number of scan lines
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vsync_left_reg <= 5'h00;
        else if (vsync_start)
            vsync_left_reg <= VSYNC_LINES;
        else if (line_end && vsync_left_reg != 5'h00)
            vsync_left_reg <= vsync_left_reg - 5'h01;
    end

    // ==========================================================
    // Refresh address: reload per frame, per row scan line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ma_reg        <= 14'h0000;
            row_start_reg <= 14'h0000;
        end
        else if (frame_end)
        begin
            ma_reg        <= start_address_reg;
            row_start_reg <= start_address_reg;
        end
        else if (line_end && row_end)
        begin
            ma_reg        <= next_row_start;
            row_start_reg <= next_row_start;
        end
        else if (line_end)
            ma_reg <= row_start_reg;
        else if (h_active)
            ma_reg <= ma_reg + 14'h0001;
    end

    // Blink counter steps once per frame; field flag toggles per frame only when interlaced, else clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            field_reg       <= 1'b0;
            blink_count_reg <= 5'h00;
        end
        else if (frame_end)
        begin
            field_reg       <= interlaced ? !field_reg : 1'b0;
            blink_count_reg <= blink_count_reg + 5'h01;
        end
    end

    // ==========================================================
    // Outputs; adjust lines keep counting the raster row
    wire [1:0] cursor_mode  = cursor_start_reg[CURSOR_MODE_LSB +: 2];
    wire       blink_on     = !cursor_mode[1] ||
                              (cursor_mode == CURSOR_MODE_FAST ? blink_count_reg[BLINK_FAST_BIT]
                                                               : blink_count_reg[BLINK_SLOW_BIT]);
    wire       cursor_line  = (raster_row_address >= cursor_start_reg[4:0]) &&
                              (raster_row_address <= cursor_end_reg);

    assign refresh_memory_address = ma_reg;
    assign raster_row_address     = (vstate_reg == V_ADJUST) ? adjust_count_reg : row_line_reg;
    assign horizontal_sync        = (hsync_left_reg != 4'h0);
    assign vertical_sync          = (vsync_left_reg != 5'h00);
    assign display_enable         = h_active && v_active;
    assign cursor_active          = display_enable && (ma_reg == cursor_location_reg) && cursor_line &&
                                    (cursor_mode != CURSOR_MODE_OFF) && blink_on;
    assign interlace_field        = field_reg;

endmodule

// ==== crt_raster_timing_generator_properties.sv ====
// Port-level timing checker for the raster generator
`timescale 1ns/1ns
module crt_raster_timing_generator_checker
    import crt_timing_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [6:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pen_strobe_input,
    input wire logic [13:0] refresh_memory_address,
    input wire logic [4:0]  raster_row_address,
    input wire logic        horizontal_sync,
    input wire logic        vertical_sync,
    input wire logic        display_enable,
    input wire logic        cursor_active,
    input wire logic        interlace_field
);
    // ==========================================================
    // Shadow registers and interval counters
    logic [7:0]  ht, hsp;
    logic [3:0]  hsw;
    logic [6:0]  vt;
    logic [4:0]  va, ms;
    logic [13:0] cur;
    logic [1:0]  armed;
    logic [15:0] hcnt, fcnt;
    wire logic       wr = psel & penable & pwrite;
    wire logic [4:0] wi = paddr[6:2];
    wire logic [15:0] fexp = (({9'h0, vt} + 16'h1) * ({11'h0, ms} + 16'h1) + {11'h0, va}) * ({8'h0, ht} + 16'h1);

    // Any write disarms all but the cursor check until two frames of settled geometry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ht <= RST_HORIZONTAL_TOTAL;
            hsp <= RST_HSYNC_POSITION;
            hsw <= RST_HSYNC_WIDTH;
            vt <= RST_VERTICAL_TOTAL;
            va <= RST_VERTICAL_ADJUST;
            ms <= RST_MAX_SCAN_LINE;
            cur <= 14'h0;
            armed <= 2'h0;
            hcnt <= 16'h0;
            fcnt <= 16'h0;
        end
        else
        begin
            if (wr && wi == IDX_HORIZONTAL_TOTAL) ht <= pwdata[7:0];
            if (wr && wi == IDX_HSYNC_POSITION) hsp <= pwdata[7:0];
            if (wr && wi == IDX_HSYNC_WIDTH) hsw <= pwdata[3:0];
            if (wr && wi == IDX_VERTICAL_TOTAL) vt <= pwdata[6:0];
            if (wr && wi == IDX_VERTICAL_ADJUST) va <= pwdata[4:0];
            if (wr && wi == IDX_MAX_SCAN_LINE) ms <= pwdata[4:0];
            if (wr && wi == IDX_CURSOR_HIGH) cur[13:8] <= pwdata[5:0];
            if (wr && wi == IDX_CURSOR_LOW) cur[7:0] <= pwdata[7:0];
            armed <= wr ? 2'h0 : ($rose(vertical_sync) && armed != 2'h3) ? armed + 2'h1 : armed;
            hcnt <= $rose(horizontal_sync) ? 16'h1 : hcnt + 16'h1;
            fcnt <= $rose(vertical_sync) ? 16'h1 : fcnt + 16'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_line_period: assert property ($rose(horizontal_sync) && armed >= 2'h2 |-> hcnt == {8'h0, ht} + 16'h1)
        else $error("scan line length wrong");
    chk_hsync_width: assert property ($fell(horizontal_sync) && armed >= 2'h2 |-> hcnt == {12'h0, hsw})
        else $error("horizontal sync width wrong");
    chk_hsync_position: assert property ($rose(display_enable) && armed >= 2'h2 && hsw != 4'h0 |-> hcnt == {8'h0, ht} - {8'h0, hsp})
        else $error("horizontal sync position wrong");
    chk_frame_period: assert property ($rose(vertical_sync) && armed >= 2'h2 |-> fcnt == fexp)
        else $error("frame length wrong");
    chk_address_advance: assert property (armed >= 2'h2 && display_enable ##1 display_enable |-> refresh_memory_address == $past(refresh_memory_address) + 14'h1)
        else $error("refresh address did not advance");
    chk_row_held: assert property (armed >= 2'h2 && display_enable ##1 display_enable |-> $stable(raster_row_address))
        else $error("row address moved within a line");
    chk_row_bounded: assert property (armed >= 2'h2 && display_enable |-> raster_row_address <= ms)
        else $error("row address beyond last scan line");
    chk_cursor_match: assert property (cursor_active |-> display_enable && refresh_memory_address == cur)
        else $error("cursor away from its address");
endmodule

bind crt_raster_timing_generator crt_raster_timing_generator_checker checker_inst (.*);

// ==== crt_monitor_model.sv ====
// Monitor line counter and light pen model at the raster outputs
`timescale 1ns/1ns
module crt_monitor_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        horizontal_sync,
    input  wire logic        vertical_sync,
    input  wire logic [13:0] refresh_memory_address,
    input  wire logic        pen_fire,
    output logic             pen_strobe_input,
    output logic [13:0]      pen_seen_address,
    output logic [15:0]      lines_per_frame
);
    // ==========================================================
    // Lines between frame syncs; pen pulse follows the request
    logic        hsync_last, vsync_last;
    logic [15:0] line_count;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {hsync_last, vsync_last, pen_strobe_input} <= 3'h0;
            {line_count, lines_per_frame} <= 32'h0;
            pen_seen_address <= 14'h0;
        end
        else
        begin
            hsync_last <= horizontal_sync;
            vsync_last <= vertical_sync;
            if (vertical_sync && !vsync_last)
                {lines_per_frame, line_count} <= {line_count, 16'h0};
            else if (horizontal_sync && !hsync_last)
                line_count <= line_count + 16'h1;
            pen_strobe_input <= pen_fire; // Pen line idles low
            if (pen_fire && !pen_strobe_input) pen_seen_address <= refresh_memory_address;
        end
    end
endmodule

// ==== tb.sv ====
// Self-checking bench: APB stimulus, raster model and verdict
`timescale 1ns/1ns
module tb;
    import crt_timing_pkg::*;
    localparam int HT = 13, HD = 4, HSP = 6, HSW = 3, VT = 9, VD = 4, VSP = 5, MS = 1;
    logic        pclk, presetn, psel, penable, pwrite, pen_fire, err, f0;
    logic        pready, pslverr, pen_strobe_input, horizontal_sync, vertical_sync;
    logic        display_enable, cursor_active, interlace_field;
    logic [6:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] refresh_memory_address, pen_seen_address;
    logic [4:0]  raster_row_address;
    logic [15:0] lines_per_frame;
    int          mismatches, comparisons, cycles, seed, st, cur, n, k;
    int          tbl [16];

    // Every port meets the bench signal of the same name
    crt_raster_timing_generator DUT (.*);
    crt_monitor_model far_side (.pclk(pclk), .presetn(presetn), .horizontal_sync(horizontal_sync),
        .vertical_sync(vertical_sync), .refresh_memory_address(refresh_memory_address), .pen_fire(pen_fire),
        .pen_strobe_input(pen_strobe_input), .pen_seen_address(pen_seen_address),
        .lines_per_frame(lines_per_frame));

    // ==========================================================
    // Clock and hang guard
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000) // Roughly five times the planned run
        begin
            mismatches++;
            print_verdict;
        end
    end

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task apb(input logic [4:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task vrise;
        while (vertical_sync !== 1'b0) @(posedge pclk);
        while (vertical_sync !== 1'b1) @(posedge pclk);
    endtask

    // Reference raster: every displayed clock of the next frame's rows
    task frame(input int sa);
        int r, l, h, gap, a;
        vrise;
        for (r = 0; r < VD; r++)
            for (l = 0; l <= MS; l++)
            begin
                gap = 0;
                while (display_enable !== 1'b1)
                begin
                    gap++;
                    @(posedge pclk);
                end
                if (r + l > 0) check("blank clocks", HT + 1 - HD, gap);
                for (h = 0; h < HD; h++)
                begin
                    a = (sa + r * HD + h) & 32'h3fff;
                    check("refresh address", a, refresh_memory_address);
                    check("row address", l, raster_row_address);
                    check("cursor", a == cur, cursor_active);
                    @(posedge pclk);
                end
            end
    endtask

    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, pen_fire, presetn} = 5'h0;
        paddr = 7'h0;
        pwdata = 32'h0;
        seed = 18;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        st = $random(seed) & 32'h3fff;
        cur = (st + HD + 1) & 32'h3fff;
        tbl = '{HT, HD, HSP, HSW, VT, 1, VD, VSP, 0, MS, 0, MS, st >> 8, st & 255, cur >> 8, cur & 255};
        for (n = 0; n < 16; n++) apb(5'(n), 1'b1, 8'(tbl[n]));
        apb(IDX_CURSOR_HIGH, 1'b0, 8'h0);
        check("cursor high", cur >> 8, rd);
        apb(IDX_CURSOR_LOW, 1'b0, 8'h0);
        check("cursor low", cur & 255, rd);
        apb(IDX_PEN_HIGH, 1'b1, 8'hff);
        apb(IDX_PEN_HIGH, 1'b0, 8'h0);
        check("pen high after write", 0, rd);
        apb(5'h13, 1'b0, 8'h0);
        check("unmapped error", 1, err);
        check("unmapped data", 0, rd);
        frame(st);
        st = $random(seed) & 32'h3fff;
        apb(IDX_START_HIGH, 1'b1, 8'(st >> 8));
        apb(IDX_START_LOW, 1'b1, 8'(st));
        frame(st);
        for (n = 3; n >= 0; n -= 3)
        begin
            apb(IDX_VERTICAL_ADJUST, 1'b1, 8'(n));
            repeat (3) vrise;
            check("lines per frame", (VT + 1) * (MS + 1) + n, lines_per_frame);
        end
        for (n = 0; n <= HSW; n++)
        begin
            apb(IDX_HSYNC_WIDTH, 1'b1, 8'(n));
            repeat (2) vrise;
            k = 0;
            repeat (2 * (HT + 1)) @(posedge pclk) k += (horizontal_sync === 1'b1);
            check("sync clocks in two lines", 2 * n, k);
        end
        for (n = 0; n < 4; n++)
        begin
            apb(IDX_INTERLACE_MODE, 1'b1, 8'(n));
            vrise;
            f0 = interlace_field;
            vrise;
            check("field flag", n[0] ? !f0 : 1'b0, interlace_field);
        end
        apb(IDX_INTERLACE_MODE, 1'b1, 8'h0);
        // Strobe placed in the retrace gap, where the address holds still
        while (display_enable !== 1'b1) @(posedge pclk);
        while (display_enable !== 1'b0) @(posedge pclk);
        pen_fire <= 1'b1;
        repeat (4) @(posedge pclk);
        pen_fire <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(IDX_PEN_HIGH, 1'b0, 8'h0);
        check("pen high", pen_seen_address >> 8, rd);
        apb(IDX_PEN_LOW, 1'b0, 8'h0);
        check("pen low", pen_seen_address & 14'hff, rd);
        print_verdict;
    end
endmodule
